// ===== logic/xfer_ctl_defines.svh
// Constants for the transfer and control instruction decoder.
// Assumes inclusion by bare name from the decoder source.
`ifndef XFER_CTL_DEFINES_SVH
`define XFER_CTL_DEFINES_SVH
`define OP_XRD_R0   8'h80
`define OP_XRD_R1   8'h81
`define OP_XWR_R0   8'h90
`define OP_XWR_R1   8'h91
`define OP_LATCH_P1 8'h63
`define OP_LATCH_P2 8'h73
`define OP_PBFLOAT  8'hA2
`define OP_SIGFLOAT 8'hC2
`define OP_RELEASE  8'hE2
`define OP_HALT     8'h01
`define OP_TABLE    8'hA3
`define BYTE_ZERO   8'h00
`define PA_ZERO     11'h000
`define XREG_SEL_BIT 0
`define PC_PAGE_HI   10
`define PC_PAGE_LO   8
`endif

// ===== logic/xfer_ctl_pkg.sv
// Types shared by the transfer and control instruction decoder.
// Assumes no surroundings beyond the decoder itself.
package xfer_ctl_pkg;
	typedef enum logic [3:0] {
		ST_FETCH = 4'b0001,
		ST_XRD   = 4'b0010,
		ST_XWR   = 4'b0100,
		ST_TBL   = 4'b1000
	} state_t;
endpackage

// ===== logic/mcu_transfer_control_decoder.sv
// Decoder and executor for external moves, table lookup, latch readback, float and halt opcodes.
// Assumes opcodes arrive one per cycle with op_valid_i, and memories answer within the second cycle.
`include "xfer_ctl_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module mcu_transfer_control_decoder (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// Instruction stream.
	input  wire logic        op_valid_i,
	input  wire logic [7:0]  opcode_i,
	output logic             op_ready_o,
	// Core state.
	input  wire logic [7:0]  acc_i,
	input  wire logic [7:0]  working_register0_i,
	input  wire logic [7:0]  working_register1_i,
	input  wire logic [10:0] pc_i,
	input  wire logic [7:0]  first_port_latch_i,
	input  wire logic [7:0]  second_port_latch_i,
	output logic             acc_we_o,
	output logic [7:0]       acc_wdata_o,
	// External data memory.
	output logic [7:0]       xmem_addr_o,
	output logic             xmem_rd_o,
	output logic             xmem_wr_o,
	output logic [7:0]       xmem_wdata_o,
	input  wire logic [7:0]  xmem_rdata_i,
	// Program memory.
	output logic [10:0]      pmem_addr_o,
	output logic             pmem_rd_o,
	input  wire logic [7:0]  pmem_rdata_i,
	// Float and halt controls.
	output logic             port_bus_float_o,
	output logic             output_signal_float_o,
	output logic             core_clock_halt_o
);
	logic                  rst_s1_q;
	logic                  rst_n_q;
	xfer_ctl_pkg::state_t  state_q;
	logic                  take;
	logic                  take_rd;
	logic                  take_wr;
	logic                  take_tbl;
	logic                  take_two;
	logic                  take_halt;
	logic                  take_lat1;
	logic                  take_lat2;
	logic                  take_pbf;
	logic                  take_sigf;
	logic                  take_rel;
	logic [7:0]            sel_reg;

	// True for the two external read opcodes.
	function automatic logic is_ext_read(input logic [7:0] op);
		is_ext_read = (op == `OP_XRD_R0) || (op == `OP_XRD_R1);
	endfunction

	// True for the two external write opcodes.
	function automatic logic is_ext_write(input logic [7:0] op);
		is_ext_write = (op == `OP_XWR_R0) || (op == `OP_XWR_R1);
	endfunction

	// True for the program table lookup opcode.
	function automatic logic is_table(input logic [7:0] op);
		is_table = (op == `OP_TABLE);
	endfunction

	// True for every opcode that needs a second cycle.
	function automatic logic is_two_cycle(input logic [7:0] op);
		is_two_cycle = is_ext_read(op) || is_ext_write(op) || is_table(op);
	endfunction

	// Reset release synchroniser; only the second flop feeds the logic.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// An opcode is taken only in fetch state while not halted.
	assign take = op_valid_i && (state_q == xfer_ctl_pkg::ST_FETCH) && !core_clock_halt_o;

	// Per-opcode take strobes, so each process tests one plain condition.
	assign take_rd   = take && is_ext_read(opcode_i);
	assign take_wr   = take && is_ext_write(opcode_i);
	assign take_tbl  = take && is_table(opcode_i);
	assign take_two  = take && is_two_cycle(opcode_i);
	assign take_halt = take && (opcode_i == `OP_HALT);
	assign take_lat1 = take && (opcode_i == `OP_LATCH_P1);
	assign take_lat2 = take && (opcode_i == `OP_LATCH_P2);
	assign take_pbf  = take && (opcode_i == `OP_PBFLOAT);
	assign take_sigf = take && (opcode_i == `OP_SIGFLOAT);
	assign take_rel  = take && (opcode_i == `OP_RELEASE);

	// The lowest opcode bit picks which working register holds the address.
	assign sel_reg = opcode_i[`XREG_SEL_BIT] ? working_register1_i : working_register0_i;

	// Sequencer for the two-cycle instructions; every second cycle returns to fetch.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= xfer_ctl_pkg::ST_FETCH;
		end else begin
			case (state_q)
				xfer_ctl_pkg::ST_FETCH: begin
					if (take_rd) begin
						state_q <= xfer_ctl_pkg::ST_XRD;
					end else if (take_wr) begin
						state_q <= xfer_ctl_pkg::ST_XWR;
					end else if (take_tbl) begin
						state_q <= xfer_ctl_pkg::ST_TBL;
					end
				end
				xfer_ctl_pkg::ST_XRD: begin
					state_q <= xfer_ctl_pkg::ST_FETCH;
				end
				xfer_ctl_pkg::ST_XWR: begin
					state_q <= xfer_ctl_pkg::ST_FETCH;
				end
				xfer_ctl_pkg::ST_TBL: begin
					state_q <= xfer_ctl_pkg::ST_FETCH;
				end
				default: begin
					state_q <= xfer_ctl_pkg::ST_FETCH;
				end
			endcase
		end
	end

	// Ready drops for the second cycle of a two-cycle opcode and for good once halted.
	// A halt taken this cycle must already pull ready low, since the latch shows it one edge later.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			op_ready_o <= 1'b0;
		end else begin
			op_ready_o <= !core_clock_halt_o && !take_halt && !take_two;
		end
	end

	// External memory strobes are one-cycle pulses in the second cycle.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			xmem_rd_o <= 1'b0;
			xmem_wr_o <= 1'b0;
		end else begin
			xmem_rd_o <= take_rd;
			xmem_wr_o <= take_wr;
		end
	end

	// Address and write data stand from the take until the next take.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			xmem_addr_o  <= `BYTE_ZERO;
			xmem_wdata_o <= `BYTE_ZERO;
		end else if (take) begin
			xmem_addr_o  <= sel_reg;
			xmem_wdata_o <= acc_i;
		end
	end

	// Program memory lookup strobe and address for the table instruction.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pmem_addr_o <= `PA_ZERO;
			pmem_rd_o   <= 1'b0;
		end else begin
			pmem_rd_o <= take_tbl;
			if (take_tbl) begin
				pmem_addr_o <= {pc_i[`PC_PAGE_HI:`PC_PAGE_LO], acc_i};
			end
		end
	end

	// Accumulator write-back; memories return data during the strobe cycle.
	// Latch readback uses the output latch inputs, never the pin levels.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			acc_we_o    <= 1'b0;
			acc_wdata_o <= `BYTE_ZERO;
		end else if (state_q == xfer_ctl_pkg::ST_XRD) begin
			acc_we_o    <= 1'b1;
			acc_wdata_o <= xmem_rdata_i;
		end else if (state_q == xfer_ctl_pkg::ST_TBL) begin
			acc_we_o    <= 1'b1;
			acc_wdata_o <= pmem_rdata_i;
		end else if (take_lat1) begin
			acc_we_o    <= 1'b1;
			acc_wdata_o <= first_port_latch_i;
		end else if (take_lat2) begin
			acc_we_o    <= 1'b1;
			acc_wdata_o <= second_port_latch_i;
		end else begin
			acc_we_o    <= 1'b0;
		end
	end

	// Port and bus float state, set by its opcode and cleared by the release opcode.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			port_bus_float_o <= 1'b0;
		end else if (take_pbf) begin
			port_bus_float_o <= 1'b1;
		end else if (take_rel) begin
			port_bus_float_o <= 1'b0;
		end
	end

	// Control output float state, set by its opcode and cleared by the release opcode.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			output_signal_float_o <= 1'b0;
		end else if (take_sigf) begin
			output_signal_float_o <= 1'b1;
		end else if (take_rel) begin
			output_signal_float_o <= 1'b0;
		end
	end

	// Halt latch; only reset restarts execution, so a halted core ignores every opcode.
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			core_clock_halt_o <= 1'b0;
		end else if (take_halt) begin
			core_clock_halt_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== bench/xfer_mem_model.sv
// Model of external data memory and program memory.
// Assumes zero wait states: data shows in the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module xfer_mem_model (
	input  wire logic        clk_i, rd_i, wr_i, prd_i,
	input  wire logic [7:0]  addr_i, wdata_i,
	input  wire logic [10:0] paddr_i,
	output logic [7:0]       rdata_o, prdata_o
);
	logic [7:0] mem[256];
	logic [7:0] last_q = 8'h00;
	// Data shows only under its strobe; otherwise the bus toggles.
	assign rdata_o = rd_i ? mem[addr_i] : ~last_q;
	assign prdata_o = prd_i ? paddr_i[7:0] ^ {5'h00, paddr_i[10:8]} : ~last_q;
	// Writes land under the write strobe.
	always @(posedge clk_i) begin
		if (wr_i)
			mem[addr_i] <= wdata_i;
		last_q <= rdata_o;
	end
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
endmodule
`default_nettype wire

// ===== bench/mcu_transfer_control_decoder_props.sv
// Port assertions for the decoder.
// Assumes binding to the decoder top by matching names.
`timescale 1ns/10ps
`default_nettype none
module xfer_ctl_props (
	input wire logic        clk_i, arst_n_i, op_valid_i, op_ready_o, acc_we_o, xmem_rd_o, xmem_wr_o, pmem_rd_o,
	input wire logic        port_bus_float_o, output_signal_float_o, core_clock_halt_o,
	input wire logic [7:0]  opcode_i, acc_i, working_register0_i, working_register1_i, first_port_latch_i,
	input wire logic [7:0]  second_port_latch_i,
	input wire logic [7:0]  acc_wdata_o, xmem_addr_o, xmem_rdata_i,
	input wire logic [10:0] pc_i, pmem_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// A take is a valid opcode while the decoder is ready.
	wire logic t = op_valid_i && op_ready_o;
	a_read_addr: assert property (t && opcode_i[7:1] == 7'h40 |=> xmem_rd_o && xmem_addr_o ==
		($past(opcode_i[0]) ? $past(working_register1_i) : $past(working_register0_i))) else $error("read");
	a_read_data: assert property (xmem_rd_o |=> acc_we_o && acc_wdata_o == $past(xmem_rdata_i)) else $error("rdata");
	a_write_once: assert property (t && opcode_i[7:1] == 7'h48 |=> xmem_wr_o ##1 !xmem_wr_o) else $error("write");
	a_latch_copy: assert property (t && opcode_i == 8'h63 |=> acc_we_o && acc_wdata_o == $past(first_port_latch_i))
		else $error("latch");
	a_latch2_copy: assert property (t && opcode_i == 8'h73 |=> acc_we_o && acc_wdata_o == $past(second_port_latch_i))
		else $error("latch2");
	a_float_set: assert property (t && opcode_i == 8'hA2 |=> port_bus_float_o) else $error("float");
	a_sigfloat_set: assert property (t && opcode_i == 8'hC2 |=> output_signal_float_o) else $error("sigfloat");
	a_float_clear: assert property (t && opcode_i == 8'hE2 |=> !port_bus_float_o && !output_signal_float_o)
		else $error("release");
	a_halt_stays: assert property (t && opcode_i == 8'h01 |=> (core_clock_halt_o && !op_ready_o) [*4]) else $error("halt");
	a_table_addr: assert property (t && opcode_i == 8'hA3 |=> pmem_rd_o && pmem_addr_o == {$past(pc_i[10:8]), $past(acc_i)})
		else $error("table");
endmodule
bind mcu_transfer_control_decoder xfer_ctl_props u_props (.*);
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the transfer and control decoder.
// Assumes the memory model answers in the strobe cycle.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       clk_i = 0, arst_n_i = 0, op_valid_i = 0, op_ready_o, acc_we_o, xmem_rd_o, xmem_wr_o, pmem_rd_o;
	logic       port_bus_float_o, output_signal_float_o, core_clock_halt_o, fl = 0, sf = 0, hl = 0;
	logic [7:0] opcode_i = 0, acc_i = 0, working_register0_i = 0, working_register1_i = 0, first_port_latch_i = 0;
	logic [7:0] second_port_latch_i = 0, acc_wdata_o, xmem_addr_o, xmem_wdata_o, xmem_rdata_i, pmem_rdata_i, ad, d;
	logic [10:0] pc_i = 0, pmem_addr_o;
	logic [7:0] mem[256];
	logic [7:0] ops[11] = '{8'h80, 8'h81, 8'h90, 8'h91, 8'h63, 8'h73, 8'hA2, 8'hC2, 8'hE2, 8'hA3, 8'h00};
	int         errors = 0, cmp_count = 0;
	mcu_transfer_control_decoder uut (.*);
	xfer_mem_model mdl (.clk_i(clk_i), .rd_i(xmem_rd_o), .wr_i(xmem_wr_o), .prd_i(pmem_rd_o), .addr_i(xmem_addr_o),
		.wdata_i(xmem_wdata_o), .paddr_i(pmem_addr_o), .rdata_o(xmem_rdata_i), .prdata_o(pmem_rdata_i));
	// Clock at 40 MHz.
	initial forever #12.5 clk_i = ~clk_i;
	// Counts a comparison and reports a mismatch.
	task automatic chk(string n, logic [10:0] s, logic [10:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Presents one opcode with random core state; v low means it must be ignored.
	task automatic run(logic [7:0] o, logic v);
		logic two;
		{acc_i, working_register0_i, working_register1_i} = 24'($urandom);
		{first_port_latch_i, second_port_latch_i, pc_i} = 27'($urandom);
		opcode_i = o;
		op_valid_i = 1;
		@(negedge clk_i);
		two = v && (o[7:5] == 3'h4 || o == 8'hA3);
		ad = o[0] ? working_register1_i : working_register0_i;
		fl = v && o == 8'hA2 || fl && !(v && o == 8'hE2);
		sf = v && o == 8'hC2 || sf && !(v && o == 8'hE2);
		hl = hl || v && o == 8'h01;
		chk("rd", xmem_rd_o, v && o[7:4] == 4'h8);
		chk("wr", xmem_wr_o, v && o[7:4] == 4'h9);
		chk("prd", pmem_rd_o, v && o == 8'hA3);
		chk("pfl", port_bus_float_o, fl);
		chk("sfl", output_signal_float_o, sf);
		chk("hlt", core_clock_halt_o, hl);
		chk("rdy", op_ready_o, !hl && !two);
		chk("we", acc_we_o, v && o[7:5] == 3'h3);
		if (v && o[7:5] == 3'h3)
			chk("lat", acc_wdata_o, o[4] ? second_port_latch_i : first_port_latch_i);
		if (two) begin
			// The gap cycle carries no request, so the next call raises valid a cycle later.
			op_valid_i = 0;
			chk("adr", o == 8'hA3 ? pmem_addr_o : xmem_addr_o, o == 8'hA3 ? {pc_i[10:8], acc_i} : ad);
			if (o[4])
				chk("wd", xmem_wdata_o, acc_i);
			if (o[4])
				mem[ad] = acc_i;
			d = o == 8'hA3 ? acc_i ^ {5'h00, pc_i[10:8]} : mem[ad];
			@(negedge clk_i);
			chk("we2", acc_we_o, !o[4]);
			if (!o[4])
				chk("dat", acc_wdata_o, d);
		end
	endtask
	// Main sequence: a sweep of every opcode but halt, random ones, then halt and two opcodes that must be ignored.
	initial begin
		void'($urandom(32'h18B1857F));
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
		repeat (4) @(negedge clk_i);
		arst_n_i = 1;
		repeat (3) @(negedge clk_i);
		for (int k = 0; k < 70; k++) run(ops[k < 11 ? k : $urandom_range(10)], 1);
		run(8'h01, 1);
		run(8'h63, 0);
		run(8'hE2, 0);
		end_of_test;
	end
	// Cuts a hung run short.
	initial begin
		#20us;
		errors++;
		end_of_test;
	end
endmodule
`default_nettype wire
